/* logic/usb_ctl_pkg.sv */
package usb_ctl_pkg;

  // Word offsets of the register map (byte addresses)
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] ADDR_OFF   = 8'h04;
  localparam logic [7:0] TOKEN_OFF  = 8'h08;
  localparam logic [7:0] SOF_OFF    = 8'h0c;
  localparam logic [7:0] CFG1_OFF   = 8'h10;
  localparam logic [7:0] MODE_OFF   = 8'h14;

  // Control register field positions
  localparam int CTL_JST_B    = 7;
  localparam int CTL_SE0_B    = 6;
  localparam int CTL_PKTBSY_B = 5;
  localparam int CTL_BUSRST_B = 4;
  localparam int CTL_HOST_B   = 3;
  localparam int CTL_RESUME_B = 2;
  localparam int CTL_PPRST_B  = 1;
  localparam int CTL_EN_B     = 0;

  // Config 1 field positions
  localparam int CFG_EYE_B  = 7;
  localparam int CFG_OEM_B  = 6;
  localparam int CFG_SIDL_B = 4;

  // Mode register field positions
  localparam int MODE_OTG_B   = 0;
  localparam int MODE_TRDIS_B = 1;

  // Token type codes
  localparam logic [3:0] TOK_SETUP = 4'hd;
  localparam logic [3:0] TOK_IN    = 4'h9;
  localparam logic [3:0] TOK_OUT   = 4'h1;

  // Ping-pong configurations
  localparam logic [1:0] PP_NONE  = 2'h0;
  localparam logic [1:0] PP_EP0O  = 2'h1;
  localparam logic [1:0] PP_ALL   = 2'h2;
  localparam logic [1:0] PP_EP1UP = 2'h3;

  // Threshold overhead in bytes
  localparam logic [7:0] SOF_OVERHEAD = 8'h0a;

  // Reset values
  localparam logic [7:0] BYTE_RST = 8'h00;

  // Frame timing
  localparam int CLK_MHZ      = 200;
  localparam int FRAME_US     = 1000;
  localparam int FRAME_CYCLES = FRAME_US * CLK_MHZ;

  // Bus line state from the transceiver
  typedef struct packed {
    logic dp;
    logic dm;
  } line_t;

  // Pull resistor controls
  typedef struct packed {
    logic dp_up;
    logic dp_down;
    logic dm_up;
    logic dm_down;
  } pulls_t;

endpackage : usb_ctl_pkg

/* logic/usb_otg_control_config_regs.sv */
// Behaviour
// - Live read-only flag shows single-ended zero on the bus lines.
// - Device mode: packet disable stops processing; set by SETUP receipt.
// - Host enable activates host and both data-line pull-downs.
// - Device mode: module enable attaches device with D+ pull-up.
// - Ping-pong reset forces every endpoint pointer to even bank.
// - Host mode: live flag shows J state, speed dependent polarity.
// - Host mode: busy flag high while a token executes.
// - Host mode: frame-start enable sends one SOF token per millisecond.
// - Low-speed select active in host mode; reads zero in device mode.
// - Seven-bit read-write device address in low bits.
// - Token types SETUP 1101, IN 1001, OUT 0001; others reserved.
// - Frame-start threshold equals largest packet size plus ten.
// - Eye-pattern control places transceiver in eye test mode.
// - Output-enable monitor drives active-low OE when transceiver disabled.
// - Stop-in-idle halts the module while the device is idle.
// - Ping-pong config selects even/odd buffering per endpoint group.
// - Resume control drives resume signalling while set.
// - Unimplemented bits, including upper bytes, read as zero.
// - OTG enable clear: pulls follow host and module enables.
// - Transceiver disable switches to the external transceiver interface.
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module usb_otg_control_config_regs #(
  parameter int FRAME_CYCLES = usb_ctl_pkg::FRAME_CYCLES
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire usb_ctl_pkg::line_t   line_in,
  input  wire logic                 setup_rx,
  input  wire logic                 token_done,
  input  wire logic                 idle_mode,
  input  wire logic                 line_drive,
  input  wire logic                 sof_sent,
  output usb_ctl_pkg::pulls_t       pulls,
  output logic                      host_mode,
  output logic                      module_run,
  output logic                      packet_processing_disable,
  output logic                      bus_reset_out,
  output logic                      resume_out,
  output logic                      pp_reset,
  output logic      [1:0]           pingpong_config_field,
  output logic                      eye_pattern_test_enable,
  output logic                      transceiver_disable,
  output logic                      ext_oe_n,
  output logic                      low_speed_select,
  output logic      [6:0]           device_address,
  output logic                      token_start,
  output logic      [3:0]           token_type_field,
  output logic      [3:0]           token_endpoint_field,
  output logic      [7:0]           frame_start_threshold_count,
  output logic                      sof_request
);

  localparam int FCW = $clog2(FRAME_CYCLES + 1);
  localparam logic [FCW-1:0] FRAME_LAST = FCW'(FRAME_CYCLES - 1);

  // Two-flop synchronisers for the bus line pins
  logic [1:0] line_s1_r;
  logic [1:0] line_s2_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_s1_r <= 2'h0;
      line_s2_r <= 2'h0;
    end else begin
      line_s1_r <= {line_in.dp, line_in.dm};
      line_s2_r <= line_s1_r;
    end
  end

  // Register storage
  logic       pkt_dis_r;
  logic       bus_rst_r;
  logic       host_en_r;
  logic       resume_r;
  logic       pp_rst_r;
  logic       en_r;
  logic       lspd_r;
  logic [6:0] addr_r;
  logic [3:0] tok_pid_r;
  logic [3:0] tok_ep_r;
  logic       tok_busy_r;
  logic [7:0] sof_cnt_r;
  logic       eye_r;
  logic       oemon_r;
  logic       sidl_r;
  logic [1:0] pp_cfg_r;
  logic       otg_en_r;
  logic       trdis_r;

  // Bus decode
  wire wr_en   = psel && penable && pwrite;
  wire wr_ctrl = wr_en && (paddr == usb_ctl_pkg::CTRL_OFF);
  wire wr_addr = wr_en && (paddr == usb_ctl_pkg::ADDR_OFF);
  wire wr_tok  = wr_en && (paddr == usb_ctl_pkg::TOKEN_OFF);
  wire wr_sof  = wr_en && (paddr == usb_ctl_pkg::SOF_OFF);
  wire wr_cfg  = wr_en && (paddr == usb_ctl_pkg::CFG1_OFF);
  wire wr_mode = wr_en && (paddr == usb_ctl_pkg::MODE_OFF);
  wire mapped  = (paddr == usb_ctl_pkg::CTRL_OFF)  ||
                 (paddr == usb_ctl_pkg::ADDR_OFF)  ||
                 (paddr == usb_ctl_pkg::TOKEN_OFF) ||
                 (paddr == usb_ctl_pkg::SOF_OFF)   ||
                 (paddr == usb_ctl_pkg::CFG1_OFF)  ||
                 (paddr == usb_ctl_pkg::MODE_OFF);

  // Live line state
  wire se0_live = (line_s2_r == 2'h0);
  wire jst_live = lspd_r ? (line_s2_r == 2'h1)
                         : (line_s2_r == 2'h2);
  wire is_host  = host_en_r;

  // Control register writes; live flags are not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_rst_r <= 1'b0;
      host_en_r <= 1'b0;
      resume_r  <= 1'b0;
      pp_rst_r  <= 1'b0;
      en_r      <= 1'b0;
    end else if (wr_ctrl) begin
      bus_rst_r <= pwdata[usb_ctl_pkg::CTL_BUSRST_B] && is_host;
      host_en_r <= pwdata[usb_ctl_pkg::CTL_HOST_B];
      resume_r  <= pwdata[usb_ctl_pkg::CTL_RESUME_B];
      pp_rst_r  <= pwdata[usb_ctl_pkg::CTL_PPRST_B];
      en_r      <= pwdata[usb_ctl_pkg::CTL_EN_B];
    end
  end

  // Packet disable: SETUP receipt wins over a software clear
  wire pkt_dis_nxt = (setup_rx && !is_host) ? 1'b1 :
                     (wr_ctrl && !is_host) ?
                       pwdata[usb_ctl_pkg::CTL_PKTBSY_B] : pkt_dis_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pkt_dis_r <= 1'b0;
    else          pkt_dis_r <= pkt_dis_nxt;
  end

  // Token busy: set by a token write, cleared on completion
  wire tok_busy_nxt = (wr_tok && is_host) ? 1'b1 :
                      token_done ? 1'b0 : tok_busy_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tok_busy_r <= 1'b0;
    else          tok_busy_r <= tok_busy_nxt;
  end

  // Address, token, threshold, config and mode registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lspd_r    <= 1'b0;
      addr_r    <= 7'h00;
      tok_pid_r <= 4'h0;
      tok_ep_r  <= 4'h0;
      sof_cnt_r <= usb_ctl_pkg::BYTE_RST;
      eye_r     <= 1'b0;
      oemon_r   <= 1'b0;
      sidl_r    <= 1'b0;
      pp_cfg_r  <= usb_ctl_pkg::PP_NONE;
      otg_en_r  <= 1'b0;
      trdis_r   <= 1'b0;
    end else begin
      if (wr_addr) begin
        lspd_r <= pwdata[7];
        addr_r <= pwdata[6:0];
      end
      if (wr_tok) begin
        tok_pid_r <= pwdata[7:4];
        tok_ep_r  <= pwdata[3:0];
      end
      if (wr_sof) sof_cnt_r <= pwdata[7:0];
      if (wr_cfg) begin
        eye_r   <= pwdata[usb_ctl_pkg::CFG_EYE_B];
        oemon_r <= pwdata[usb_ctl_pkg::CFG_OEM_B];
        sidl_r  <= pwdata[usb_ctl_pkg::CFG_SIDL_B];
        pp_cfg_r <= pwdata[1:0];
      end
      if (wr_mode) begin
        otg_en_r <= pwdata[usb_ctl_pkg::MODE_OTG_B];
        trdis_r  <= pwdata[usb_ctl_pkg::MODE_TRDIS_B];
      end
    end
  end

  // Software pull control under OTG features
  logic [3:0] sw_pulls_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)                sw_pulls_r <= 4'h0;
    else if (wr_mode)            sw_pulls_r <= pwdata[7:4];
  end

  // Frame timer: one SOF request per millisecond
  logic [FCW-1:0] frame_cnt_r;
  logic           sof_req_r;
  wire pp_sof_en = en_r;                                    // Host view bit 0
  wire sof_run = is_host && module_run && pp_sof_en;
  wire frame_end = (frame_cnt_r == FRAME_LAST);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_cnt_r <= '0;
      sof_req_r   <= 1'b0;
    end else if (!sof_run) begin
      frame_cnt_r <= '0;
      sof_req_r   <= 1'b0;
    end else begin
      frame_cnt_r <= frame_end ? '0 : frame_cnt_r + 1'b1;
      sof_req_r   <= frame_end || (sof_req_r && !sof_sent);
    end
  end

  // Read data assembly, unimplemented bits zero
  wire [7:0] ctrl_dev  = {1'b0, se0_live, pkt_dis_r, 1'b0,
                          host_en_r, resume_r, pp_rst_r, en_r};
  wire [7:0] ctrl_host = {jst_live, se0_live, tok_busy_r, bus_rst_r,
                          host_en_r, resume_r, pp_rst_r, en_r};
  wire [7:0] ctrl_rd   = is_host ? ctrl_host : ctrl_dev;
  wire [7:0] addr_rd   = {lspd_r && is_host, addr_r};
  wire [7:0] cfg_rd    = {eye_r, oemon_r, 1'b0, sidl_r, 2'h0, pp_cfg_r};
  wire [7:0] mode_rd   = {sw_pulls_r, 2'h0, trdis_r, otg_en_r};
  wire [7:0] rd_byte   =
    (paddr == usb_ctl_pkg::CTRL_OFF)  ? ctrl_rd :
    (paddr == usb_ctl_pkg::ADDR_OFF)  ? addr_rd :
    (paddr == usb_ctl_pkg::TOKEN_OFF) ? {tok_pid_r, tok_ep_r} :
    (paddr == usb_ctl_pkg::SOF_OFF)   ? sof_cnt_r :
    (paddr == usb_ctl_pkg::CFG1_OFF)  ? cfg_rd :
    (paddr == usb_ctl_pkg::MODE_OFF)  ? mode_rd : 8'h00;

  // Registered read data, upper bits zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= {24'h00_0000, rd_byte};
  end

  // Zero-wait APB answer; unmapped addresses error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Pull resistors: hardware or software control
  wire hw_dp_up = en_r && !host_en_r;
  always_comb begin
    if (otg_en_r) begin
      pulls = usb_ctl_pkg::pulls_t'(sw_pulls_r);
    end else begin
      pulls.dp_up   = hw_dp_up;
      pulls.dm_up   = 1'b0;
      pulls.dp_down = host_en_r;
      pulls.dm_down = host_en_r;
    end
  end

  // Control outputs
  assign module_run    = (en_r || host_en_r) &&
                         !(sidl_r && idle_mode);
  assign host_mode     = host_en_r;
  assign packet_processing_disable = pkt_dis_r;
  assign bus_reset_out = bus_rst_r;
  assign resume_out    = resume_r;
  assign pp_reset      = pp_rst_r;
  assign pingpong_config_field   = pp_cfg_r;
  assign eye_pattern_test_enable = eye_r;
  assign transceiver_disable     = trdis_r;
  assign ext_oe_n = !(oemon_r && trdis_r && line_drive);
  assign low_speed_select = lspd_r && is_host;
  assign device_address   = addr_r;
  assign token_start      = tok_busy_r;
  assign token_type_field = tok_pid_r;
  assign token_endpoint_field        = tok_ep_r;
  assign frame_start_threshold_count = sof_cnt_r;
  assign sof_request      = sof_req_r;

  property p_setup_sets_disable;
    @(posedge pclk) disable iff (!presetn)
      (setup_rx && !is_host) |=> pkt_dis_r;
  endproperty
  a_setup_sets_disable: assert property (p_setup_sets_disable)
    else $error("packet disable not set by setup");

  property p_host_pulldowns;
    @(posedge pclk) disable iff (!presetn)
      (!otg_en_r && host_en_r) |-> (pulls.dp_down && pulls.dm_down);
  endproperty
  a_host_pulldowns: assert property (p_host_pulldowns)
    else $error("host pull-downs missing");

  property p_dev_pullup;
    @(posedge pclk) disable iff (!presetn)
      (!otg_en_r && !host_en_r) |-> (pulls.dp_up == en_r);
  endproperty
  a_dev_pullup: assert property (p_dev_pullup)
    else $error("device pull-up wrong");

  property p_oe_gate;
    @(posedge pclk) disable iff (!presetn)
      !(oemon_r && trdis_r) |-> ext_oe_n;
  endproperty
  a_oe_gate: assert property (p_oe_gate)
    else $error("oe driven while monitor inactive");

  sequence s_tok_issue;
    wr_tok && is_host;
  endsequence
  property p_tok_busy;
    @(posedge pclk) disable iff (!presetn)
      s_tok_issue ##1 !token_done |=> tok_busy_r;
  endproperty
  a_tok_busy: assert property (p_tok_busy)
    else $error("token busy not held");

  property p_sof_rate;
    @(posedge pclk) disable iff (!presetn)
      $rose(sof_req_r) |-> ##1 (frame_cnt_r == FCW'(1) || !sof_run);
  endproperty
  a_sof_rate: assert property (p_sof_rate)
    else $error("sof request off frame boundary");

  property p_sof_off;
    @(posedge pclk) disable iff (!presetn)
      !sof_run |=> !sof_req_r;
  endproperty
  a_sof_off: assert property (p_sof_off)
    else $error("sof request while disabled");

  property p_lspd_dev;
    @(posedge pclk) disable iff (!presetn)
      !is_host |-> !low_speed_select;
  endproperty
  a_lspd_dev: assert property (p_lspd_dev)
    else $error("low speed active in device mode");

  property p_idle_stop;
    @(posedge pclk) disable iff (!presetn)
      (sidl_r && idle_mode) |-> !module_run;
  endproperty
  a_idle_stop: assert property (p_idle_stop)
    else $error("module runs in idle");

  property p_tok_done_clears;
    @(posedge pclk) disable iff (!presetn)
      (token_done && !(wr_tok && is_host)) |=> !tok_busy_r;
  endproperty
  a_tok_done_clears: assert property (p_tok_done_clears)
    else $error("token busy not cleared on completion");

  property p_sw_clears_pkt;
    @(posedge pclk) disable iff (!presetn)
      (wr_ctrl && !is_host && !setup_rx &&
       !pwdata[usb_ctl_pkg::CTL_PKTBSY_B]) |=> !pkt_dis_r;
  endproperty
  a_sw_clears_pkt: assert property (p_sw_clears_pkt)
    else $error("packet disable not cleared by software");

  property p_sof_on_wrap;
    @(posedge pclk) disable iff (!presetn)
      (sof_run && frame_end) |=> sof_req_r;
  endproperty
  a_sof_on_wrap: assert property (p_sof_on_wrap)
    else $error("no sof request at frame end");

  property p_rd_upper_zero;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite) |=> (prdata[31:8] == 24'h00_0000);
  endproperty
  a_rd_upper_zero: assert property (p_rd_upper_zero)
    else $error("read data upper bits not zero");

endmodule : usb_otg_control_config_regs

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  localparam int FC = 20;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, err, setup_go = 0, idle_mode = 0;
  logic [3:0] lat = 4'h1;
  usb_ctl_pkg::line_t line_set = 2'b10, line_in;
  usb_ctl_pkg::pulls_t pulls;
  logic setup_rx, token_done, sof_sent, line_drive, host_mode, module_run;
  logic packet_processing_disable, bus_reset_out, resume_out, pp_reset;
  logic eye_pattern_test_enable, transceiver_disable, ext_oe_n;
  logic low_speed_select, token_start, sof_request;
  logic [1:0] pingpong_config_field;
  logic [6:0] device_address;
  logic [3:0] token_type_field, token_endpoint_field;
  logic [7:0] frame_start_threshold_count;
  int n_errors = 0, n_checks = 0, cyc = 0;

  always #2.5 pclk = ~pclk;

  usb_otg_control_config_regs #(.FRAME_CYCLES(FC)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_in(line_in),
    .setup_rx(setup_rx), .token_done(token_done), .idle_mode(idle_mode),
    .line_drive(line_drive), .sof_sent(sof_sent), .pulls(pulls),
    .host_mode(host_mode), .module_run(module_run),
    .packet_processing_disable(packet_processing_disable),
    .bus_reset_out(bus_reset_out), .resume_out(resume_out),
    .pp_reset(pp_reset), .pingpong_config_field(pingpong_config_field),
    .eye_pattern_test_enable(eye_pattern_test_enable),
    .transceiver_disable(transceiver_disable), .ext_oe_n(ext_oe_n),
    .low_speed_select(low_speed_select), .device_address(device_address),
    .token_start(token_start), .token_type_field(token_type_field),
    .token_endpoint_field(token_endpoint_field),
    .frame_start_threshold_count(frame_start_threshold_count),
    .sof_request(sof_request));

  usb_far_end far_u (
    .pclk(pclk), .presetn(presetn), .token_start(token_start),
    .sof_request(sof_request), .setup_go(setup_go), .lat(lat),
    .line_set(line_set), .line_in(line_in), .setup_rx(setup_rx),
    .token_done(token_done), .sof_sent(sof_sent), .line_drive(line_drive));

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One APB transfer; read data and error taken at the pready edge
  task automatic apb(input logic        w,
                     input logic [7:0]  a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ends at the first edge with pready high; the hang guard ends it if pready never rises
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb

  task automatic rdc(input string       nm,
                     input logic [7:0]  a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rv, e);
  endtask : rdc

  task automatic t_reset;
    // Line synchronisers need two edges before the live flags settle
    repeat (2) @(posedge pclk);
    for (int i = 0; i < 6; i++) begin
      rdc("rst", 8'(i * 4), 32'h0);
    end
    rdc("unmapped", 8'h18, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
  endtask : t_reset

  task automatic t_regs;
    logic [31:0] thr;
    thr = 32'(8'h40 + usb_ctl_pkg::SOF_OVERHEAD);
    apb(1'b1, usb_ctl_pkg::ADDR_OFF, 32'hffffffff);
    rdc("addr_dev", usb_ctl_pkg::ADDR_OFF, 32'h7f);
    chk("dev_addr", 32'(device_address), 32'h7f);
    apb(1'b1, usb_ctl_pkg::CFG1_OFF, 32'hffffffff);
    rdc("cfg1", usb_ctl_pkg::CFG1_OFF, 32'hd3);
    chk("eye", 32'(eye_pattern_test_enable), 32'h1);
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, usb_ctl_pkg::CFG1_OFF, 32'(p));
      chk("ppcfg", 32'(pingpong_config_field), 32'(p));
    end
    chk("eye_off", 32'(eye_pattern_test_enable), 32'h0);
    // 64-byte packets plus the fixed overhead
    apb(1'b1, usb_ctl_pkg::SOF_OFF, thr);
    rdc("sof_thr", usb_ctl_pkg::SOF_OFF, 32'h4a);
    chk("thr_out", 32'(frame_start_threshold_count), thr);
    // Clear the stored speed bit so later J reads are full speed
    apb(1'b1, usb_ctl_pkg::ADDR_OFF, 32'h0);
  endtask : t_regs

  task automatic t_device;
    apb(1'b1, usb_ctl_pkg::CTRL_OFF, 32'h000000f7);
    rdc("ctl_dev", usb_ctl_pkg::CTRL_OFF, 32'h27);
    chk("bus_rst", 32'(bus_reset_out), 32'h0);
    chk("host_d", 32'(host_mode), 32'h0);
    chk("resume", 32'(resume_out), 32'h1);
    chk("pp_rst", 32'(pp_reset), 32'h1);
    chk("pulls_d", {28'h0, pulls}, 32'h8);
    apb(1'b1, usb_ctl_pkg::CTRL_OFF, 32'h1);
    chk("pkt_clr", 32'(packet_processing_disable), 32'h0);
    setup_go <= 1'b1;
    @(posedge pclk);
    setup_go <= 1'b0;
    line_set <= 2'b00;
    repeat (5) @(posedge pclk);
    rdc("se0", usb_ctl_pkg::CTRL_OFF, 32'h61);
    chk("pkt_set", 32'(packet_processing_disable), 32'h1);
    apb(1'b1, usb_ctl_pkg::CFG1_OFF, 32'h10);
    idle_mode <= 1'b1;
    @(posedge pclk);
    #1 chk("run_idle", 32'(module_run), 32'h0);
    apb(1'b1, usb_ctl_pkg::CFG1_OFF, 32'h0);
    chk("run_go", 32'(module_run), 32'h1);
    apb(1'b1, usb_ctl_pkg::CTRL_OFF, 32'h0);
    chk("detach", {28'h0, pulls}, 32'h0);
    line_set <= 2'b10;
    idle_mode <= 1'b0;
  endtask : t_device

  task automatic t_host;
    apb(1'b1, usb_ctl_pkg::CTRL_OFF, 32'h28);
    rdc("ctl_host", usb_ctl_pkg::CTRL_OFF, 32'h88);
    chk("host", 32'(host_mode), 32'h1);
    chk("pulls_h", {28'h0, pulls}, 32'h5);
    apb(1'b1, usb_ctl_pkg::ADDR_OFF, 32'h80);
    chk("ls", 32'(low_speed_select), 32'h1);
    rdc("fs_j_ls", usb_ctl_pkg::CTRL_OFF, 32'h08);
    apb(1'b1, usb_ctl_pkg::ADDR_OFF, 32'h0);
    apb(1'b1, usb_ctl_pkg::MODE_OFF, 32'ha1);
    chk("pulls_sw", {28'h0, pulls}, 32'ha);
    apb(1'b1, usb_ctl_pkg::MODE_OFF, 32'h0);
    apb(1'b1, usb_ctl_pkg::CTRL_OFF, 32'h1c);
    chk("bus_reset_control", 32'(bus_reset_out), 32'h1);
    chk("resume_h", 32'(resume_out), 32'h1);
    repeat (10) @(posedge pclk);
    apb(1'b1, usb_ctl_pkg::CTRL_OFF, 32'h08);
    chk("rst_end", {30'h0, bus_reset_out, resume_out}, 32'h0);
  endtask : t_host

  task automatic t_token;
    logic [3:0]  ids[3];
    logic [31:0] wd;
    int          n;
    ids = '{usb_ctl_pkg::TOK_SETUP, usb_ctl_pkg::TOK_IN,
            usb_ctl_pkg::TOK_OUT};
    apb(1'b1, usb_ctl_pkg::MODE_OFF, 32'h2);
    apb(1'b1, usb_ctl_pkg::CFG1_OFF, 32'h40);
    chk("trdis", 32'(transceiver_disable), 32'h1);
    for (int i = 0; i < 3; i++) begin
      lat <= 4'(3 + i * 4);
      wd = {24'h0, ids[i], 4'(i + 1)};
      apb(1'b1, usb_ctl_pkg::TOKEN_OFF, wd);
      chk("busy", 32'(token_start), 32'h1);
      chk("pid", 32'(token_type_field), 32'(ids[i]));
      chk("ep", 32'(token_endpoint_field), 32'(i + 1));
      rdc("busy_rd", usb_ctl_pkg::CTRL_OFF, 32'ha8);
      chk("oe_n", 32'(ext_oe_n), 32'h0);
      n = 0;
      while (token_start === 1'b1 && n < 40) begin
        @(posedge pclk);
        n++;
      end
      #1 rdc("idle_rd", usb_ctl_pkg::CTRL_OFF, 32'h88);
      chk("oe_off", 32'(ext_oe_n), 32'h1);
    end
  endtask : t_token

  task automatic t_sof;
    int n;
    lat <= 4'h2;
    apb(1'b1, usb_ctl_pkg::CTRL_OFF, 32'h09);
    n = 0;
    repeat (FC * 10) @(posedge pclk) n += int'(sof_sent);
    chk("sof_on", 32'(n >= 9 && n <= 11), 32'h1);
    apb(1'b1, usb_ctl_pkg::CTRL_OFF, 32'h08);
    repeat (8) @(posedge pclk);
    n = 0;
    repeat (FC * 5) @(posedge pclk) n += int'(sof_sent);
    chk("sof_off", 32'(n), 32'h0);
    chk("sof_req", 32'(sof_request), 32'h0);
  endtask : t_sof

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_device();
    t_host();
    t_token();
    t_sof();
    give_verdict();
  end
endmodule : tb_top

/* tb/usb_far_end.sv */
`timescale 1ns/1ps
// Far side of the link: answers tokens and frame starts, sets line state
module usb_far_end (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                token_start,
  input  wire logic                sof_request,
  input  wire logic                setup_go,
  input  wire logic [3:0]          lat,
  input  wire usb_ctl_pkg::line_t  line_set,
  output usb_ctl_pkg::line_t       line_in,
  output logic                     setup_rx,
  output logic                     token_done,
  output logic                     sof_sent,
  output logic                     line_drive
);
  logic [3:0] tcnt_r;
  logic [3:0] scnt_r;

  // Line levels come straight from the scenario
  assign line_in = line_set;

  // Token answer after lat cycles, lines driven meanwhile
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcnt_r <= 4'h0;
      token_done <= 1'b0;
      line_drive <= 1'b0;
      setup_rx <= 1'b0;
    end else begin
      setup_rx <= setup_go;
      line_drive <= token_start & ~token_done;
      token_done <= 1'b0;
      if (!token_start || token_done) tcnt_r <= 4'h0;
      else if (tcnt_r >= lat) token_done <= 1'b1;
      else tcnt_r <= tcnt_r + 4'h1;
    end
  end

  // Frame start acknowledge after lat cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scnt_r <= 4'h0;
      sof_sent <= 1'b0;
    end else begin
      sof_sent <= 1'b0;
      if (!sof_request || sof_sent) scnt_r <= 4'h0;
      else if (scnt_r >= lat) sof_sent <= 1'b1;
      else scnt_r <= scnt_r + 4'h1;
    end
  end
endmodule : usb_far_end
